// *** akc_composer.sv ***
`timescale 1ns/1ps
`include "akc_defs.svh"

// Overview of operation
// - switching commands ride only in the two switching bytes of each frame.
// - first byte carries the switch request; second carries extra information.
// - one ring/span mode governs decoding in both directions; staged and sent bytes do not depend on it.
// - staged byte loads as zeros, ones, alternating default, or any value.
// - ring: no request 0000, reverse ring 0001, reverse span 0010.
// - ring: exerciser ring 0011, exerciser span 0100, wait-to-restore 0101.
// - ring: manual switch ring 0110, manual switch span 0111.
// - ring: degrade ring 1000, degrade span 1001, degrade protection 1010.
// - ring: signal fail ring 1011, signal fail span 1100.
// - ring: forced ring 1101, forced span 1110, lockout span 1111.
// - span: none 0000, no-revert 0001, reverse 0010, exerciser 0100, wtr 0110.
// - span: manual 1000, degrade low 1010, degrade high 1011.
// - span: fail low 1100, fail high 1101, forced 1110, lockout 1111.
// - span codes 0011, 0101, 0111, 1001 decode as unused.
// - low nibble is a plain number zero to fifteen in either mode.
// - staging edits never touch transmit; only a transmit action copies.
// - transmit-default forces both bytes to zeros, transmit-illegal to ones.
// - no transmit update while line alarm or far-end failure is sent.
// - received bytes are captured and decoded per the current mode.
module akc_composer import akc_pkg::*; #(
    parameter int KW = 8
) (
    // clock, reset, enable
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    // mode
    input wire logic mode_ring_in,
    // staging
    input wire logic setup_load_in,
    input wire logic setup_k2_in,
    input wire akc_sel_t setup_sel_in,
    input wire logic [7:0] setup_byte_in,
    input wire logic setup_req_we_in,
    input wire logic [3:0] setup_req_in,
    input wire logic setup_num_we_in,
    input wire logic [3:0] setup_num_in,
    // transmit action and line alarms
    input wire logic tx_go_in,
    input wire akc_tx_t tx_cmd_in,
    input wire logic line_ais_in,
    input wire logic line_ferf_in,
    // receive side
    input wire logic rx_frame_in,
    input wire akc_kpair_t rx_bytes_in,
    // status and bytes
    output logic mode_ring_out,
    output akc_kpair_t setup_out,
    output akc_kpair_t tx_bytes_out,
    output logic tx_refused_out,
    output akc_kpair_t rx_bytes_out,
    output logic rx_new_out,
    output akc_dec_t tx_dec_out,
    output akc_dec_t rx_dec_out
);

    // ----------------------------------------------------------------
    // parameter check
    // ----------------------------------------------------------------
    if (KW != 8) begin : g_kw_check
        $error("akc_composer: switching bytes are eight bits wide");
    end

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic next_mode_ring;
    akc_kpair_t next_setup;
    akc_kpair_t next_tx_bytes;
    logic next_tx_refused;
    akc_kpair_t next_rx_bytes;
    logic next_rx_new;
    akc_dec_t next_tx_dec;
    akc_dec_t next_rx_dec;
    akc_dec_t tx_dec_w;
    akc_dec_t rx_dec_w;

    // picks the pattern for a staged byte
    function automatic logic [7:0] pick_pattern(input akc_sel_t sel,
                                                input logic [7:0] val);
        logic [7:0] res;
        res = val;
        unique case (sel)
            SEL_ZEROS: res = `AKC_PAT_ZEROS;
            SEL_ONES: res = `AKC_PAT_ONES;
            SEL_DEFAULT: res = `AKC_PAT_DEFAULT;
            SEL_USER: res = val;
        endcase
        return res;
    endfunction

    // ----------------------------------------------------------------
    // mode register
    // ----------------------------------------------------------------
    // one mode for both directions
    always_comb begin
        next_mode_ring = mode_ring_in;
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mode_ring_out <= 1'b0;
        end else if (ce_in) begin
            mode_ring_out <= next_mode_ring;
        end
    end

    // ----------------------------------------------------------------
    // staged setup bytes
    // ----------------------------------------------------------------
    // full-byte load wins over nibble edits in the same cycle
    always_comb begin
        next_setup = setup_out;
        if (setup_load_in) begin
            if (setup_k2_in) begin
                next_setup.k2 = pick_pattern(setup_sel_in,
                                             setup_byte_in);
            end else begin
                next_setup.k1 = pick_pattern(setup_sel_in,
                                             setup_byte_in);
            end
        end else begin
            if (setup_req_we_in) begin
                next_setup.k1[`AKC_REQ_MSB:`AKC_REQ_LSB] =
                    setup_req_in;
            end
            if (setup_num_we_in) begin
                next_setup.k1[`AKC_NUM_MSB:`AKC_NUM_LSB] =
                    setup_num_in;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            setup_out <= {`AKC_RST_BYTE, `AKC_RST_BYTE};
        end else if (ce_in) begin
            setup_out <= next_setup;
        end
    end

    // ----------------------------------------------------------------
    // transmitted bytes
    // ----------------------------------------------------------------
    // only a transmit action changes the sent bytes; alarms block it
    always_comb begin
        next_tx_bytes = tx_bytes_out;
        next_tx_refused = 1'b0;
        if (tx_go_in && tx_cmd_in != TX_NONE) begin
            if (line_ais_in || line_ferf_in) begin
                next_tx_refused = 1'b1;
            end else begin
                unique case (tx_cmd_in)
                    TX_USER: next_tx_bytes = setup_out;
                    TX_DEFAULT: next_tx_bytes =
                        {`AKC_TX_DEFAULT, `AKC_TX_DEFAULT};
                    TX_ILLEGAL: next_tx_bytes =
                        {`AKC_TX_ILLEGAL, `AKC_TX_ILLEGAL};
                    TX_NONE: next_tx_bytes = tx_bytes_out;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tx_bytes_out <= {`AKC_RST_BYTE, `AKC_RST_BYTE};
            tx_refused_out <= 1'b0;
        end else if (ce_in) begin
            tx_bytes_out <= next_tx_bytes;
            tx_refused_out <= next_tx_refused;
        end
    end

    // ----------------------------------------------------------------
    // received bytes
    // ----------------------------------------------------------------
    // capture the pair once per frame strobe
    always_comb begin
        next_rx_bytes = rx_bytes_out;
        next_rx_new = 1'b0;
        if (rx_frame_in) begin
            next_rx_bytes = rx_bytes_in;
            next_rx_new = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rx_bytes_out <= {`AKC_RST_BYTE, `AKC_RST_BYTE};
            rx_new_out <= 1'b0;
        end else if (ce_in) begin
            rx_bytes_out <= next_rx_bytes;
            rx_new_out <= next_rx_new;
        end
    end

    // ----------------------------------------------------------------
    // decoding of the request-bearing byte
    // ----------------------------------------------------------------
    // first byte alone holds the request
    akc_decode u_tx_dec (
        .mode_ring_in(mode_ring_out),
        .byte_in(tx_bytes_out.k1),
        .dec_out(tx_dec_w)
    );

    akc_decode u_rx_dec (
        .mode_ring_in(mode_ring_out),
        .byte_in(rx_bytes_out.k1),
        .dec_out(rx_dec_w)
    );

    // register the decoded views
    always_comb begin
        next_tx_dec = tx_dec_w;
        next_rx_dec = rx_dec_w;
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tx_dec_out <= '{req: REQ_NONE, named: 1'b1, num: 4'h0};
            rx_dec_out <= '{req: REQ_NONE, named: 1'b1, num: 4'h0};
        end else if (ce_in) begin
            tx_dec_out <= next_tx_dec;
            rx_dec_out <= next_rx_dec;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rstn_in);

    tx_hold_a: assert property (
        ce_in && !tx_go_in |=> $stable(tx_bytes_out))
        else $error("sent bytes changed without a transmit action");

    tx_user_a: assert property (
        ce_in && tx_go_in && tx_cmd_in == TX_USER && !line_ais_in
        && !line_ferf_in |=> tx_bytes_out == $past(setup_out))
        else $error("transmit user setup did not copy staged bytes");

    tx_zero_a: assert property (
        ce_in && tx_go_in && tx_cmd_in == TX_DEFAULT && !line_ais_in
        && !line_ferf_in |=> tx_bytes_out == 16'h0000)
        else $error("transmit default did not clear both bytes");

    tx_ones_a: assert property (
        ce_in && tx_go_in && tx_cmd_in == TX_ILLEGAL && !line_ais_in
        && !line_ferf_in |=> tx_bytes_out == 16'hFFFF)
        else $error("transmit illegal did not set both bytes");

    tx_block_a: assert property (
        ce_in && tx_go_in && tx_cmd_in != TX_NONE
        && (line_ais_in || line_ferf_in)
        |=> $stable(tx_bytes_out) && tx_refused_out)
        else $error("sent bytes changed during a line alarm");

    setup_pat_a: assert property (
        ce_in && setup_load_in && !setup_k2_in
        && setup_sel_in == SEL_DEFAULT |=> setup_out.k1 == 8'hAA)
        else $error("default staging pattern not loaded");

    rx_capture_a: assert property (
        ce_in && rx_frame_in
        |=> rx_bytes_out == $past(rx_bytes_in) && rx_new_out)
        else $error("received bytes not captured");

    rx_number_a: assert property (
        ce_in |=> rx_dec_out.num == $past(rx_bytes_out.k1[3:0]))
        else $error("number field not decoded from low nibble");

    span_unused_a: assert property (
        ce_in && !mode_ring_out && rx_bytes_out.k1[7:4] == 4'h3
        |=> !rx_dec_out.named && rx_dec_out.req == REQ_UNUSED)
        else $error("unused span code decoded as named");

    ring_lock_a: assert property (
        ce_in && mode_ring_out && rx_bytes_out.k1[7:4] == 4'hF
        |=> rx_dec_out.req == REQ_LO_SPAN)
        else $error("ring lockout code misdecoded");

endmodule

// *** akc_defs.svh ***
`ifndef AKC_DEFS_SVH
`define AKC_DEFS_SVH

// ----------------------------------------------------------------
// byte layout: bit 7 of the byte is the msb
// ----------------------------------------------------------------
`define AKC_REQ_MSB 7
`define AKC_REQ_LSB 4
`define AKC_NUM_MSB 3
`define AKC_NUM_LSB 0

// ----------------------------------------------------------------
// staging patterns and transmit forcing values
// ----------------------------------------------------------------
`define AKC_PAT_ZEROS 8'h00
`define AKC_PAT_ONES 8'hFF
`define AKC_PAT_DEFAULT 8'hAA
`define AKC_TX_DEFAULT 8'h00
`define AKC_TX_ILLEGAL 8'hFF
`define AKC_RST_BYTE 8'h00

// ----------------------------------------------------------------
// request codes, ring mode
// ----------------------------------------------------------------
`define AKC_RING_NR 4'h0
`define AKC_RING_RR_R 4'h1
`define AKC_RING_RR_S 4'h2
`define AKC_RING_EX_R 4'h3
`define AKC_RING_EX_S 4'h4
`define AKC_RING_WTR 4'h5
`define AKC_RING_MS_R 4'h6
`define AKC_RING_MS_S 4'h7
`define AKC_RING_SD_R 4'h8
`define AKC_RING_SD_S 4'h9
`define AKC_RING_SD_P 4'hA
`define AKC_RING_SF_R 4'hB
`define AKC_RING_SF_S 4'hC
`define AKC_RING_FS_R 4'hD
`define AKC_RING_FS_S 4'hE
`define AKC_RING_LO_S 4'hF

// ----------------------------------------------------------------
// request codes, span mode
// ----------------------------------------------------------------
`define AKC_SPAN_NR 4'h0
`define AKC_SPAN_DNR 4'h1
`define AKC_SPAN_RR 4'h2
`define AKC_SPAN_UN3 4'h3
`define AKC_SPAN_EX 4'h4
`define AKC_SPAN_UN5 4'h5
`define AKC_SPAN_WTR 4'h6
`define AKC_SPAN_UN7 4'h7
`define AKC_SPAN_MS 4'h8
`define AKC_SPAN_UN9 4'h9
`define AKC_SPAN_SD_LO 4'hA
`define AKC_SPAN_SD_HI 4'hB
`define AKC_SPAN_SF_LO 4'hC
`define AKC_SPAN_SF_HI 4'hD
`define AKC_SPAN_FS 4'hE
`define AKC_SPAN_LO 4'hF

`endif

// *** akc_pkg.sv ***
package akc_pkg;

    // staged byte source
    typedef enum logic [1:0] {
        SEL_ZEROS = 2'b00, SEL_ONES = 2'b01,
        SEL_DEFAULT = 2'b10, SEL_USER = 2'b11
    } akc_sel_t;

    // transmit action
    typedef enum logic [1:0] {
        TX_USER = 2'b00, TX_DEFAULT = 2'b01,
        TX_ILLEGAL = 2'b10, TX_NONE = 2'b11
    } akc_tx_t;

    // decoded request names for both modes
    typedef enum logic [4:0] {
        REQ_NONE = 5'b00000, REQ_RR_RING = 5'b00001,
        REQ_RR_SPAN = 5'b00010, REQ_EX_RING = 5'b00011,
        REQ_EX_SPAN = 5'b00100, REQ_WTR = 5'b00101,
        REQ_MS_RING = 5'b00110, REQ_MS_SPAN = 5'b00111,
        REQ_SD_RING = 5'b01000, REQ_SD_SPAN = 5'b01001,
        REQ_SD_PROT = 5'b01010, REQ_SF_RING = 5'b01011,
        REQ_SF_SPAN = 5'b01100, REQ_FS_RING = 5'b01101,
        REQ_FS_SPAN = 5'b01110, REQ_LO_SPAN = 5'b01111,
        REQ_DNR = 5'b10000, REQ_RR = 5'b10001,
        REQ_EX = 5'b10010, REQ_MS = 5'b10011,
        REQ_SD_LO = 5'b10100, REQ_SD_HI = 5'b10101,
        REQ_SF_LO = 5'b10110, REQ_SF_HI = 5'b10111,
        REQ_FS = 5'b11000, REQ_LO = 5'b11001,
        REQ_UNUSED = 5'b11010
    } akc_req_t;

    // the two switching bytes of one frame
    typedef struct packed {
        logic [7:0] k1;
        logic [7:0] k2;
    } akc_kpair_t;

    // decoded first switching byte
    typedef struct packed {
        akc_req_t req;
        logic named;
        logic [3:0] num;
    } akc_dec_t;

endpackage

// *** akc_decode.sv ***
`timescale 1ns/1ps
`include "akc_defs.svh"

module akc_decode import akc_pkg::*; (
    // mode and byte
    input wire logic mode_ring_in,
    input wire logic [7:0] byte_in,
    // decoded result
    output akc_dec_t dec_out
);

    logic [3:0] code;

    // ----------------------------------------------------------------
    // request field and number field
    // ----------------------------------------------------------------
    // upper nibble is the request, lower nibble the number
    assign code = byte_in[`AKC_REQ_MSB:`AKC_REQ_LSB];

    // request name depends on the mode
    always_comb begin
        dec_out.num = byte_in[`AKC_NUM_MSB:`AKC_NUM_LSB];
        dec_out.named = 1'b1;
        dec_out.req = REQ_NONE;
        if (mode_ring_in) begin
            unique case (code)
                `AKC_RING_NR: dec_out.req = REQ_NONE;
                `AKC_RING_RR_R: dec_out.req = REQ_RR_RING;
                `AKC_RING_RR_S: dec_out.req = REQ_RR_SPAN;
                `AKC_RING_EX_R: dec_out.req = REQ_EX_RING;
                `AKC_RING_EX_S: dec_out.req = REQ_EX_SPAN;
                `AKC_RING_WTR: dec_out.req = REQ_WTR;
                `AKC_RING_MS_R: dec_out.req = REQ_MS_RING;
                `AKC_RING_MS_S: dec_out.req = REQ_MS_SPAN;
                `AKC_RING_SD_R: dec_out.req = REQ_SD_RING;
                `AKC_RING_SD_S: dec_out.req = REQ_SD_SPAN;
                `AKC_RING_SD_P: dec_out.req = REQ_SD_PROT;
                `AKC_RING_SF_R: dec_out.req = REQ_SF_RING;
                `AKC_RING_SF_S: dec_out.req = REQ_SF_SPAN;
                `AKC_RING_FS_R: dec_out.req = REQ_FS_RING;
                `AKC_RING_FS_S: dec_out.req = REQ_FS_SPAN;
                `AKC_RING_LO_S: dec_out.req = REQ_LO_SPAN;
            endcase
        end else begin
            unique case (code)
                `AKC_SPAN_NR: dec_out.req = REQ_NONE;
                `AKC_SPAN_DNR: dec_out.req = REQ_DNR;
                `AKC_SPAN_RR: dec_out.req = REQ_RR;
                `AKC_SPAN_EX: dec_out.req = REQ_EX;
                `AKC_SPAN_WTR: dec_out.req = REQ_WTR;
                `AKC_SPAN_MS: dec_out.req = REQ_MS;
                `AKC_SPAN_SD_LO: dec_out.req = REQ_SD_LO;
                `AKC_SPAN_SD_HI: dec_out.req = REQ_SD_HI;
                `AKC_SPAN_SF_LO: dec_out.req = REQ_SF_LO;
                `AKC_SPAN_SF_HI: dec_out.req = REQ_SF_HI;
                `AKC_SPAN_FS: dec_out.req = REQ_FS;
                `AKC_SPAN_LO: dec_out.req = REQ_LO;
                `AKC_SPAN_UN3, `AKC_SPAN_UN5, `AKC_SPAN_UN7,
                `AKC_SPAN_UN9: begin
                    dec_out.req = REQ_UNUSED;
                    dec_out.named = 1'b0;
                end
            endcase
        end
    end

endmodule

// *** akc_net_model.sv ***
`timescale 1ns/1ps

// ----------------------------------------------------------------
// network element model: frames switching byte pairs onto the line
// ----------------------------------------------------------------
module akc_net_model import akc_pkg::*; (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    // request from the bench
    input wire logic send_in,
    input wire akc_kpair_t pair_in,
    // line side
    output logic rx_frame_out,
    output akc_kpair_t rx_bytes_out
);
    akc_kpair_t last;

    // frame strobe one cycle after a send, both bytes as one pair
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rx_frame_out <= 1'b0;
            last <= 16'h0000;
        end else begin
            rx_frame_out <= send_in;
            if (send_in) begin
                last <= pair_in;
            end
        end
    end

    // outside a frame the line shows the inverse of the last pair
    assign rx_bytes_out = rx_frame_out ? last : akc_kpair_t'(~last);
endmodule

// *** tb_aps_k1_overhead_composer.sv ***
`timescale 1ns/1ps

module tb_aps_k1_overhead_composer import akc_pkg::*;;
    typedef struct {
        akc_kpair_t s;
        akc_kpair_t t;
        logic r;
        akc_dec_t d;
    } akc_tb_note_t;
    logic clk_sys_in, rstn_in, ce_in, mode_ring_in, setup_load_in;
    logic setup_k2_in, setup_req_we_in, setup_num_we_in, tx_go_in;
    logic line_ais_in, line_ferf_in, rx_frame_in, send, mr;
    logic mode_ring_out, tx_refused_out, rx_new_out;
    logic [7:0] setup_byte_in;
    logic [3:0] setup_req_in, setup_num_in;
    akc_sel_t setup_sel_in;
    akc_tx_t tx_cmd_in;
    akc_kpair_t rx_bytes_in, pair, sk, tk, setup_out, tx_bytes_out;
    akc_kpair_t rx_bytes_out;
    akc_dec_t tx_dec_out, rx_dec_out, edt, edr;
    akc_tb_note_t qs[$], qt[$], qr[$], n;
    bit s_ev, t_ev, r_ev, dt_v, dr_v;
    int failures, checks;
    logic [31:0] seed = 32'h2400790A;

    akc_composer #(.KW(8)) uut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
        .ce_in(ce_in), .mode_ring_in(mode_ring_in),
        .setup_load_in(setup_load_in), .setup_k2_in(setup_k2_in),
        .setup_sel_in(setup_sel_in), .setup_byte_in(setup_byte_in),
        .setup_req_we_in(setup_req_we_in), .setup_req_in(setup_req_in),
        .setup_num_we_in(setup_num_we_in), .setup_num_in(setup_num_in),
        .tx_go_in(tx_go_in), .tx_cmd_in(tx_cmd_in),
        .line_ais_in(line_ais_in), .line_ferf_in(line_ferf_in),
        .rx_frame_in(rx_frame_in), .rx_bytes_in(rx_bytes_in),
        .mode_ring_out(mode_ring_out), .setup_out(setup_out),
        .tx_bytes_out(tx_bytes_out), .tx_refused_out(tx_refused_out),
        .rx_bytes_out(rx_bytes_out), .rx_new_out(rx_new_out),
        .tx_dec_out(tx_dec_out), .rx_dec_out(rx_dec_out));
    akc_net_model net (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
        .send_in(send), .pair_in(pair), .rx_frame_out(rx_frame_in),
        .rx_bytes_out(rx_bytes_in));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // expected decode of a first switching byte
    function automatic akc_dec_t exp_dec(input logic ring,
                                         input logic [7:0] b);
        akc_dec_t d;
        d.num = b[3:0];
        d.named = 1'b1;
        d.req = akc_req_t'({1'b0, b[7:4]});
        if (!ring) begin
            case (b[7:4])
                4'h0: d.req = REQ_NONE;
                4'h1: d.req = REQ_DNR;
                4'h2: d.req = REQ_RR;
                4'h4: d.req = REQ_EX;
                4'h6: d.req = REQ_WTR;
                4'h8: d.req = REQ_MS;
                4'hA: d.req = REQ_SD_LO;
                4'hB: d.req = REQ_SD_HI;
                4'hC: d.req = REQ_SF_LO;
                4'hD: d.req = REQ_SF_HI;
                4'hE: d.req = REQ_FS;
                4'hF: d.req = REQ_LO;
                default: begin
                    d.req = REQ_UNUSED;
                    d.named = 1'b0;
                end
            endcase
        end
        return d;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // drivers: each op takes two cycles, strobes drop in between; set_mode waits three
    // ----------------------------------------------------------------
    task automatic stage(input logic ld, k2, input akc_sel_t sel,
                         input logic rwe, input logic [3:0] rq,
                         input logic nwe);
        logic [31:0] r;
        logic [7:0] v;
        r = xs();
        {setup_load_in, setup_k2_in} = {ld, k2};
        setup_sel_in = sel;
        {setup_req_we_in, setup_req_in, setup_num_we_in} = {rwe, rq, nwe};
        {setup_byte_in, setup_num_in} = r[11:0];
        case (sel)
            SEL_ZEROS: v = 8'h00;
            SEL_ONES: v = 8'hFF;
            SEL_DEFAULT: v = 8'hAA;
            default: v = r[11:4];
        endcase
        if (ld && k2) sk.k2 = v;
        else if (ld) sk.k1 = v;
        else begin
            if (rwe) sk.k1[7:4] = rq;
            if (nwe) sk.k1[3:0] = r[3:0];
        end
        qs.push_back('{sk, tk, 1'b0, exp_dec(mr, tk.k1)});
        @(posedge clk_sys_in) #1;
        {setup_load_in, setup_req_we_in, setup_num_we_in} = 3'h0;
        @(posedge clk_sys_in) #1;
    endtask

    task automatic xmit(input akc_tx_t c, input logic ais, ferf);
        logic r;
        {tx_go_in, line_ais_in, line_ferf_in} = {1'b1, ais, ferf};
        tx_cmd_in = c;
        r = (c != TX_NONE) && (ais || ferf);
        if (!r && c == TX_USER) tk = sk;
        if (!r && c == TX_DEFAULT) tk = 16'h0000;
        if (!r && c == TX_ILLEGAL) tk = 16'hFFFF;
        qt.push_back('{sk, tk, r, exp_dec(mr, tk.k1)});
        @(posedge clk_sys_in) #1;
        {tx_go_in, line_ais_in, line_ferf_in} = 3'h0;
        @(posedge clk_sys_in) #1;
    endtask

    task automatic frame(input bit fix);
        logic [31:0] r;
        r = xs();
        send = 1'b1;
        pair = r[15:0];
        // one directed code per mode: ring lockout, span unused
        if (fix) pair.k1[7:4] = mr ? 4'hF : 4'h3;
        qr.push_back('{pair, tk, 1'b0, exp_dec(mr, pair.k1)});
        @(posedge clk_sys_in) #1;
        send = 1'b0;
        @(posedge clk_sys_in) #1;
    endtask

    task automatic set_mode(input logic m);
        mode_ring_in = m;
        mr = m;
        repeat (3) @(posedge clk_sys_in);
        #1;
        check(mode_ring_out, m);
    endtask

    // ----------------------------------------------------------------
    // monitor: results one cycle after an accepted op, decode one more
    // ----------------------------------------------------------------
    always @(negedge clk_sys_in) begin
        if (dt_v) check(tx_dec_out.req, edt.req);
        if (dt_v) check(tx_dec_out, edt);
        if (dr_v) check(rx_dec_out, edr);
        {dt_v, dr_v} = 2'b00;
        if (s_ev) begin
            n = qs.pop_front();
            check(setup_out, n.s);
            check(tx_bytes_out, n.t);
        end
        if (t_ev) begin
            n = qt.pop_front();
            check(tx_bytes_out, n.t);
            check(tx_refused_out, n.r);
            {edt, dt_v} = {n.d, 1'b1};
        end
        if (r_ev) begin
            n = qr.pop_front();
            check(rx_bytes_out, n.s);
            check(rx_new_out, 1'b1);
            {edr, dr_v} = {n.d, 1'b1};
        end else begin
            check(rx_new_out, 1'b0);
        end
        s_ev = rstn_in && ce_in
            && (setup_load_in || setup_req_we_in || setup_num_we_in);
        t_ev = rstn_in && ce_in && tx_go_in;
        r_ev = rstn_in && ce_in && rx_frame_in;
    end

    // clock at 200 MHz
    initial begin
        clk_sys_in = 1'b0;
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end

    // watchdog against a hang
    initial begin
        #20000;
        failures++;
        tally_and_finish();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {rstn_in, mode_ring_in, mr, setup_load_in, setup_k2_in} = 5'h0;
        {setup_req_we_in, setup_num_we_in, tx_go_in, send} = 4'h0;
        {line_ais_in, line_ferf_in, setup_req_in, setup_num_in} = 10'h0;
        ce_in = 1'b1;
        setup_sel_in = SEL_ZEROS;
        tx_cmd_in = TX_NONE;
        {setup_byte_in, pair, sk, tk} = 56'h0;
        repeat (12) @(posedge clk_sys_in);
        #1;
        rstn_in = 1'b1;
        check(tx_dec_out, {REQ_NONE, 1'b1, 4'h0});
        // every load pattern into both bytes, nibble writes lose to load
        for (int s = 0; s < 8; s++) begin
            stage(1'b1, s[0], akc_sel_t'(s[2:1]), 1'b1, 4'h5, 1'b1);
        end
        // every request code in both modes, then received frames
        for (int m = 0; m < 2; m++) begin
            set_mode(m[0]);
            for (int c = 0; c < 16; c++) begin
                stage(1'b0, 1'b0, SEL_USER, 1'b1, c[3:0], 1'b1);
                xmit(TX_USER, 1'b0, 1'b0);
            end
            for (int f = 0; f < 6; f++) begin
                frame(f == 0);
            end
        end
        // forced values, alarm refusals and the silent no-op
        xmit(TX_DEFAULT, 1'b0, 1'b0);
        xmit(TX_USER, 1'b1, 1'b0);
        xmit(TX_ILLEGAL, 1'b0, 1'b0);
        xmit(TX_DEFAULT, 1'b0, 1'b1);
        xmit(TX_NONE, 1'b1, 1'b0);
        xmit(TX_USER, 1'b0, 1'b0);
        // clock enable low: strobes are ignored and every output holds
        {ce_in, setup_load_in, tx_go_in} = 3'b011;
        tx_cmd_in = TX_ILLEGAL;
        repeat (3) @(posedge clk_sys_in);
        #1;
        check(setup_out, sk);
        check(tx_bytes_out, tk);
        {ce_in, setup_load_in, tx_go_in} = 3'b100;
        // second reset mid-run: bytes return to zero, then work resumes
        rstn_in = 1'b0;
        {sk, tk} = 32'h0;
        repeat (2) @(posedge clk_sys_in);
        #1;
        rstn_in = 1'b1;
        check(setup_out, sk);
        check(tx_bytes_out, tk);
        check(rx_bytes_out, 16'h0000);
        stage(1'b1, 1'b0, SEL_DEFAULT, 1'b0, 4'h0, 1'b0);
        xmit(TX_USER, 1'b0, 1'b0);
        repeat (4) @(posedge clk_sys_in);
        tally_and_finish();
    end
endmodule
